// [src/hscp_pkg.sv]
package hscp_pkg;

  // ==========================================================================
  // bus geometry
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int PORT_W = 16;
  localparam int N_AUX = 4;
  localparam int N_AXIS = 4;
  localparam int N_DET = 2;

  // ==========================================================================
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_COMMAND = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_DATA1 = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_DATA2 = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_DATA3 = 5'h0c;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h10;

  // ==========================================================================
  // configuration command codes
  localparam logic [7:0] CMD_OUT_SETUP = 8'h01;
  localparam logic [7:0] CMD_IN_SETUP = 8'h02;
  localparam logic [7:0] CMD_SYNC_SETUP = 8'h03;
  localparam logic [7:0] CMD_PAUSE_RELEASE = 8'h04;
  localparam logic [7:0] CMD_BATCH_IO = 8'h05;
  localparam logic [7:0] CMD_READBACK_SEL = 8'h06;

  // ==========================================================================
  // function codes, two bits per line
  localparam logic [1:0] OUTF_OFF = 2'h0;
  localparam logic [1:0] OUTF_LEVEL = 2'h1;
  localparam logic [1:0] OUTF_PULSE_SYNC = 2'h2;
  localparam logic [1:0] OUTF_PULSE_DET = 2'h3;
  localparam logic [1:0] INF_GENERAL = 2'h0;
  localparam logic [1:0] INF_SYNC_START = 2'h1;

  // readback groups for the data ports
  localparam logic [1:0] RB_OUTPUTS = 2'h0;
  localparam logic [1:0] RB_INPUTS = 2'h1;
  localparam logic [1:0] RB_SYNC_BATCH = 2'h2;

  // ==========================================================================
  // timing: pulse widths count in ticks of one microsecond
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_W = 7;

  // ==========================================================================
  // reset values
  localparam logic [PORT_W-1:0] RST_WORD = 16'h0000;

  // ==========================================================================
  // configuration carriers
  typedef struct packed {
    logic [7:0] func;          // two bits per aux output
    logic [3:0] level;         // level used by OUTF_LEVEL
    logic [15:0] width;        // pulse width in ticks
  } hscp_out_cfg_t;

  typedef struct packed {
    logic [7:0] aux_func;      // two bits per aux input
    logic [3:0] det_func;      // two bits per detector input
    logic [3:0] aux_invert;    // 1: aux input active low
    logic [1:0] det_invert;    // 1: detector input active low
  } hscp_in_cfg_t;

  typedef struct packed {
    logic [3:0] axis_mask;     // axes that take part in synchronous start
    logic batch_en;            // batch general-purpose io enabled
    logic [3:0] gp_func;       // 1: axis output pin is general-purpose
    logic [3:0] gp_level;      // batch-written general-purpose outputs
  } hscp_sync_cfg_t;

localparam hscp_out_cfg_t OUT_CFG_RST = '{func: 8'h00, level: 4'h0, width: 16'h0000};
localparam hscp_in_cfg_t IN_CFG_RST = '{aux_func: 8'h00, det_func: 4'h0, aux_invert: 4'h0,
                                         det_invert: 2'h0};
localparam hscp_sync_cfg_t SYNC_CFG_RST = '{axis_mask: 4'h0, batch_en: 1'b0, gp_func: 4'h0,
                                             gp_level: 4'h0};

endpackage : hscp_pkg

// [src/hscp_pin_sync.sv]
module hscp_pin_sync
  import hscp_pkg::*;
#(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level_out
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // ==========================================================================
  // three-stage chain; a bit changes only when stages two and three agree
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      level_out <= '0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          level_out[i] <= s3_q[i];
        end
      end
    end
  end

endmodule // hscp_pin_sync

// [src/hscp_config_port.sv]
module hscp_config_port
  import hscp_pkg::*;
(
  input wire logic SYS_CLK_IN,
  input wire logic RESET_IN,
  input wire logic [ADDR_W-1:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [DATA_W-1:0] AVS_WRITEDATA_IN,
  input wire logic [3:0] AVS_BYTEENABLE_IN,
  output logic [DATA_W-1:0] AVS_READDATA_OUT,
  output logic AVS_WAITREQUEST_OUT,
  input wire logic [N_AUX-1:0] AUX_INPUT_LINES_IN,
  input wire logic [N_DET-1:0] DETECTOR_INPUTS_IN,
  input wire logic [N_AXIS-1:0] AXIS_GP_INPUT_IN,
  input wire logic [N_AXIS-1:0] AXIS_ALT_FUNC_IN,
  output logic [N_AUX-1:0] AUX_OUTPUT_LINES_OUT,
  output logic [N_AXIS-1:0] AXIS_GP_OUTPUT_OUT,
  output logic [N_AXIS-1:0] SYNC_START_OUT
);

  logic ack_q;
  logic access;
  logic wr_en;
  logic cmd_exec;
  logic [7:0] cmd_code;
  logic [PORT_W-1:0] stage1_q;
  logic [PORT_W-1:0] stage2_q;
  logic [PORT_W-1:0] stage3_q;
  logic [7:0] last_cmd_q;
  logic [1:0] rb_sel_q;
  hscp_out_cfg_t out_cfg_q;
  hscp_in_cfg_t in_cfg_q;
  hscp_sync_cfg_t sync_cfg_q;
  logic [N_AUX-1:0] aux_sync;
  logic [N_DET-1:0] det_sync;
  logic [N_AXIS-1:0] gp_in_sync;
  logic [N_AUX-1:0] aux_act;
  logic [N_DET-1:0] det_act;
  logic [N_AUX-1:0] aux_prev_q;
  logic [N_DET-1:0] det_prev_q;
  logic [N_AUX-1:0] aux_rise;
  logic [N_DET-1:0] det_rise;
  logic sync_fire;
  logic det_fire;
  logic [TICK_W-1:0] tick_cnt_q;
  logic tick_q;
  logic [N_AUX-1:0] aux_out_d;
  logic [N_AXIS-1:0] gp_out_d;
  logic [PORT_W-1:0] status_word;
  logic [PORT_W-1:0] rd_word;

  // ==========================================================================
  // avalon slave: every request answered one cycle after it is raised
  assign access = (AVS_READ_IN || AVS_WRITE_IN) && !ack_q;
  assign wr_en = AVS_WRITE_IN && ack_q;
  assign cmd_code = stage_cmd_byte(AVS_WRITEDATA_IN);
  assign cmd_exec = wr_en && (AVS_ADDRESS_IN == OFS_COMMAND) && AVS_BYTEENABLE_IN[0];

  function automatic logic [7:0] stage_cmd_byte(input logic [DATA_W-1:0] w);
    return w[7:0];
  endfunction

  // handshake flop; waitrequest is its inverse, held high while idle
  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      ack_q <= 1'b0;
      AVS_WAITREQUEST_OUT <= 1'b1;
    end else begin
      ack_q <= access;
      AVS_WAITREQUEST_OUT <= !access;
    end
  end

  // ==========================================================================
  // data staging ports, byte lanes 0 and 1 only
  function automatic logic [PORT_W-1:0] merge(input logic [PORT_W-1:0] old,
                                               input logic [DATA_W-1:0] w,
                                               input logic [3:0] be);
    logic [PORT_W-1:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = w[7:0];
    end
    if (be[1]) begin
      r[15:8] = w[15:8];
    end
    return r;
  endfunction

  // staging words, writable at any time
  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      stage1_q <= RST_WORD;
      stage2_q <= RST_WORD;
      stage3_q <= RST_WORD;
    end else if (wr_en) begin
      case (AVS_ADDRESS_IN)
        OFS_DATA1: stage1_q <= merge(stage1_q, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
        OFS_DATA2: stage2_q <= merge(stage2_q, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
        OFS_DATA3: stage3_q <= merge(stage3_q, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // command execution: staged data become live settings
  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      last_cmd_q <= 8'h00;
      rb_sel_q <= RB_OUTPUTS;
      out_cfg_q <= OUT_CFG_RST;
      in_cfg_q <= IN_CFG_RST;
      sync_cfg_q <= SYNC_CFG_RST;
    end else if (cmd_exec) begin
      last_cmd_q <= cmd_code;
      case (cmd_code)
        CMD_OUT_SETUP: begin
          out_cfg_q.func <= stage1_q[7:0];
          out_cfg_q.level <= stage1_q[11:8];
          out_cfg_q.width <= stage2_q;
          rb_sel_q <= RB_OUTPUTS;
        end
        CMD_IN_SETUP: begin
          in_cfg_q.aux_func <= stage1_q[7:0];
          in_cfg_q.det_func <= stage1_q[11:8];
          in_cfg_q.aux_invert <= stage2_q[3:0];
          in_cfg_q.det_invert <= stage2_q[5:4];
          rb_sel_q <= RB_INPUTS;
        end
        CMD_SYNC_SETUP: begin
          sync_cfg_q.axis_mask <= stage1_q[3:0];
          rb_sel_q <= RB_SYNC_BATCH;
        end
        CMD_BATCH_IO: begin
          sync_cfg_q.batch_en <= stage1_q[0];
          sync_cfg_q.gp_level <= stage2_q[3:0];
          sync_cfg_q.gp_func <= stage3_q[3:0];
          rb_sel_q <= RB_SYNC_BATCH;
        end
        CMD_READBACK_SEL: begin
          rb_sel_q <= stage1_q[1:0];
        end
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // input pins through the three-stage synchronisers
  hscp_pin_sync #(.W(N_AUX)) u_aux_sync (
    .clk_in(SYS_CLK_IN),
    .rst_in(RESET_IN),
    .pin_in(AUX_INPUT_LINES_IN),
    .level_out(aux_sync)
  );

  hscp_pin_sync #(.W(N_DET)) u_det_sync (
    .clk_in(SYS_CLK_IN),
    .rst_in(RESET_IN),
    .pin_in(DETECTOR_INPUTS_IN),
    .level_out(det_sync)
  );

  hscp_pin_sync #(.W(N_AXIS)) u_gp_sync (
    .clk_in(SYS_CLK_IN),
    .rst_in(RESET_IN),
    .pin_in(AXIS_GP_INPUT_IN),
    .level_out(gp_in_sync)
  );

  // active levels after polarity selection
  assign aux_act = aux_sync ^ in_cfg_q.aux_invert;
  assign det_act = det_sync ^ in_cfg_q.det_invert;
  assign aux_rise = aux_act & ~aux_prev_q;
  assign det_rise = det_act & ~det_prev_q;

  // previous active levels for edge detection
  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      aux_prev_q <= '0;
      det_prev_q <= '0;
    end else begin
      aux_prev_q <= aux_act;
      det_prev_q <= det_act;
    end
  end

  // ==========================================================================
  // synchronous start sources: assigned inputs or the pause-release command
  always_comb begin
    sync_fire = cmd_exec && (cmd_code == CMD_PAUSE_RELEASE);
    det_fire = 1'b0;
    for (int i = 0; i < N_AUX; i++) begin
      if (aux_rise[i] && (in_cfg_q.aux_func[2*i +: 2] == INF_SYNC_START)) begin
        sync_fire = 1'b1;
      end
    end
    for (int i = 0; i < N_DET; i++) begin
      if (det_rise[i]) begin
        det_fire = 1'b1;
        if (in_cfg_q.det_func[2*i +: 2] == INF_SYNC_START) begin
          sync_fire = 1'b1;
        end
      end
    end
  end

  // one-cycle start pulse to the selected axes
  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      SYNC_START_OUT <= '0;
    end else begin
      SYNC_START_OUT <= sync_fire ? sync_cfg_q.axis_mask : '0;
    end
  end

  // ==========================================================================
  // microsecond tick for output pulse timing
  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (tick_cnt_q == TICK_W'(TICK_CYCLES - 1)) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + TICK_W'(1);
      tick_q <= 1'b0;
    end
  end

  // ==========================================================================
  // per-output pulse timers and output function selection
  for (genvar g = 0; g < N_AUX; g++) begin : g_aux_out
    logic [1:0] func;
    logic trig;
    logic [15:0] cnt_q;
    assign func = out_cfg_q.func[2*g +: 2];
    assign trig = ((func == OUTF_PULSE_SYNC) && sync_fire) ||
                  ((func == OUTF_PULSE_DET) && det_fire);

    // retrigger reloads the full width; counts down once per tick
    always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
        cnt_q <= '0;
      end else if (trig) begin
        cnt_q <= out_cfg_q.width;
      end else if (func != OUTF_PULSE_SYNC && func != OUTF_PULSE_DET) begin
        cnt_q <= '0;
      end else if (tick_q && (cnt_q != '0)) begin
        cnt_q <= cnt_q - 16'h0001;
      end
    end

    assign aux_out_d[g] = ((func == OUTF_LEVEL) && out_cfg_q.level[g]) ||
                          (cnt_q != '0);
  end

  // axis pins: batch level when general-purpose, else the alternate function
  always_comb begin
    for (int i = 0; i < N_AXIS; i++) begin
      gp_out_d[i] = sync_cfg_q.gp_func[i] ? (sync_cfg_q.batch_en && sync_cfg_q.gp_level[i])
                                           : AXIS_ALT_FUNC_IN[i];
    end
  end

  // registered pin drivers
  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      AUX_OUTPUT_LINES_OUT <= '0;
      AXIS_GP_OUTPUT_OUT <= '0;
    end else begin
      AUX_OUTPUT_LINES_OUT <= aux_out_d;
      AXIS_GP_OUTPUT_OUT <= gp_out_d;
    end
  end

  // ==========================================================================
  // status word assembly
  always_comb begin
    status_word = RST_WORD;
    status_word[3:0] = AUX_OUTPUT_LINES_OUT;
    status_word[11:8] = aux_act;
    if (sync_cfg_q.batch_en) begin
      status_word[7:4] = AXIS_GP_OUTPUT_OUT & sync_cfg_q.gp_func;
      status_word[15:12] = gp_in_sync;
    end
  end

  // read multiplexer; settings readback follows the selected group
  always_comb begin
    rd_word = RST_WORD;
    case (AVS_ADDRESS_IN)
      OFS_COMMAND: rd_word = {8'h00, last_cmd_q};
      OFS_DATA1: begin
        case (rb_sel_q)
          RB_OUTPUTS: rd_word = {4'h0, out_cfg_q.level, out_cfg_q.func};
          RB_INPUTS: rd_word = {4'h0, in_cfg_q.det_func, in_cfg_q.aux_func};
          RB_SYNC_BATCH: rd_word = {12'h000, sync_cfg_q.axis_mask};
          default: rd_word = RST_WORD;
        endcase
      end
      OFS_DATA2: begin
        case (rb_sel_q)
          RB_OUTPUTS: rd_word = out_cfg_q.width;
          RB_INPUTS: rd_word = {10'h000, in_cfg_q.det_invert, in_cfg_q.aux_invert};
          RB_SYNC_BATCH: rd_word = {11'h000, sync_cfg_q.gp_level, sync_cfg_q.batch_en};
          default: rd_word = RST_WORD;
        endcase
      end
      OFS_DATA3: begin
        if (rb_sel_q == RB_SYNC_BATCH) begin
          rd_word = {12'h000, sync_cfg_q.gp_func};
        end
      end
      OFS_STATUS: rd_word = status_word;
      default: rd_word = RST_WORD;
    endcase
  end

  // read data captured as waitrequest falls; zero for unmapped addresses
  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      AVS_READDATA_OUT <= '0;
    end else if (access && AVS_READ_IN) begin
      AVS_READDATA_OUT <= {16'h0000, rd_word};
    end
  end

endmodule // hscp_config_port

// [verification/hscp_config_port_assertions.sv]
module hscp_config_port_checker
  import hscp_pkg::*;
(
  input wire logic SYS_CLK_IN,
  input wire logic RESET_IN,
  input wire logic [ADDR_W-1:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [DATA_W-1:0] AVS_WRITEDATA_IN,
  input wire logic [3:0] AVS_BYTEENABLE_IN,
  input wire logic [DATA_W-1:0] AVS_READDATA_OUT,
  input wire logic AVS_WAITREQUEST_OUT,
  input wire logic [N_AUX-1:0] AUX_INPUT_LINES_IN,
  input wire logic [N_DET-1:0] DETECTOR_INPUTS_IN,
  input wire logic [N_AXIS-1:0] AXIS_GP_INPUT_IN,
  input wire logic [N_AXIS-1:0] AXIS_ALT_FUNC_IN,
  input wire logic [N_AUX-1:0] AUX_OUTPUT_LINES_OUT,
  input wire logic [N_AXIS-1:0] AXIS_GP_OUTPUT_OUT,
  input wire logic [N_AXIS-1:0] SYNC_START_OUT
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // helper terms
  wire logic pause_w = AVS_WRITE_IN && !AVS_WAITREQUEST_OUT && AVS_BYTEENABLE_IN[0] &&
                       AVS_ADDRESS_IN == OFS_COMMAND && AVS_WRITEDATA_IN[7:0] == CMD_PAUSE_RELEASE;
  wire logic mapped_w = AVS_ADDRESS_IN inside {OFS_COMMAND, OFS_DATA1, OFS_DATA2, OFS_DATA3,
                                               OFS_STATUS};

  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (RESET_IN);

  // ==========================================================================
  // bus handshake
  sequence bus_req_s;
    (AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT;
  endsequence
  sequence rd_ack_s;
    AVS_READ_IN && !AVS_WAITREQUEST_OUT;
  endsequence
  sequence stat_ack_s;
    rd_ack_s ##0 AVS_ADDRESS_IN == OFS_STATUS;
  endsequence

  req_ack_a: assert property (bus_req_s |=> !AVS_WAITREQUEST_OUT)
    else $error("request not answered one cycle later");
  wait_one_a: assert property (!AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT)
    else $error("waitrequest low longer than one cycle");
  no_spont_a: assert property (!AVS_WAITREQUEST_OUT |-> $past(AVS_READ_IN || AVS_WRITE_IN))
    else $error("answer without a request");
  unmapped_zero_a: assert property (rd_ack_s ##0 !mapped_w |-> AVS_READDATA_OUT == '0)
    else $error("unmapped read not zero");
  upper_zero_a: assert property (rd_ack_s |-> AVS_READDATA_OUT[31:16] == 16'h0000)
    else $error("upper read half not zero");

  // ==========================================================================
  // status and pins
  status_out_a: assert property (stat_ack_s |->
    AVS_READDATA_OUT[3:0] == $past(AUX_OUTPUT_LINES_OUT)) else $error("status aux bits wrong");
  gp_mask_a: assert property (stat_ack_s |->
    (AVS_READDATA_OUT[7:4] & ~$past(AXIS_GP_OUTPUT_OUT)) == 4'h0) else $error("gp bit set");
  // pause release shows one edge later, a pin change after the synchroniser and edge detect
  sync_cause_a: assert property (SYNC_START_OUT != '0 |->
    $past(pause_w) || $past(AUX_INPUT_LINES_IN, 5) != $past(AUX_INPUT_LINES_IN, 6) ||
    $past(DETECTOR_INPUTS_IN, 5) != $past(DETECTOR_INPUTS_IN, 6))
    else $error("sync start without a cause");
  sync_pulse_a: assert property (SYNC_START_OUT != '0 |=> SYNC_START_OUT == '0)
    else $error("sync start longer than one cycle");
  in_reset_a: assert property (disable iff (1'b0) RESET_IN && $past(RESET_IN) |->
    AVS_WAITREQUEST_OUT && AUX_OUTPUT_LINES_OUT == '0 && AXIS_GP_OUTPUT_OUT == '0 &&
    SYNC_START_OUT == '0) else $error("outputs not at reset values");
endmodule // hscp_config_port_checker

bind hscp_config_port hscp_config_port_checker hscp_config_port_checker_inst (
  .SYS_CLK_IN, .RESET_IN, .AVS_ADDRESS_IN, .AVS_READ_IN, .AVS_WRITE_IN, .AVS_WRITEDATA_IN,
  .AVS_BYTEENABLE_IN, .AVS_READDATA_OUT, .AVS_WAITREQUEST_OUT, .AUX_INPUT_LINES_IN,
  .DETECTOR_INPUTS_IN, .AXIS_GP_INPUT_IN, .AXIS_ALT_FUNC_IN, .AUX_OUTPUT_LINES_OUT,
  .AXIS_GP_OUTPUT_OUT, .SYNC_START_OUT
);

// [verification/test_hscp_config_port.sv]
module test_hscp_config_port
  import hscp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [31:0] data;
    logic [31:0] exp;
  } hscp_row_t;

  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [ADDR_W-1:0] address = 5'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] byte_en = 4'hf;
  logic [3:0] aux_in = 4'h0;
  logic [1:0] det_in = 2'h0;
  logic [3:0] gp_in = 4'h9;
  logic [3:0] alt_in = 4'hc;
  logic [31:0] readdata;
  logic waitreq;
  logic [3:0] aux_out;
  logic [3:0] gp_out;
  logic [3:0] sync_out;
  logic [31:0] q;
  logic [3:0] sync_val = 4'h0;
  int sync_cnt = 0;
  int miscompares = 0;
  int n_tests = 0;

  // ordinary cases: write, address, data, expected read
  hscp_row_t rows [29] = '{
    '{1'b1, OFS_DATA1, 32'h0f55, 32'h0}, '{1'b1, OFS_DATA2, 32'h0003, 32'h0},
    '{1'b1, OFS_COMMAND, 32'h01, 32'h0}, '{1'b0, OFS_DATA1, 32'h0, 32'h0f55},
    '{1'b0, OFS_DATA2, 32'h0, 32'h0003}, '{1'b0, OFS_DATA3, 32'h0, 32'h0},
    '{1'b0, OFS_COMMAND, 32'h0, 32'h01}, '{1'b0, OFS_STATUS, 32'h0, 32'h000f},
    '{1'b1, OFS_DATA1, 32'h0, 32'h0}, '{1'b1, OFS_DATA2, 32'h0001, 32'h0},
    '{1'b1, OFS_COMMAND, 32'h02, 32'h0}, '{1'b1, OFS_DATA1, 32'h0001, 32'h0},
    '{1'b1, OFS_COMMAND, 32'h06, 32'h0}, '{1'b0, OFS_DATA1, 32'h0, 32'h0},
    '{1'b0, OFS_DATA2, 32'h0, 32'h0001}, '{1'b0, OFS_STATUS, 32'h0, 32'h010f},
    '{1'b0, 5'h14, 32'h0, 32'h0}, '{1'b1, OFS_DATA1, 32'h0006, 32'h0},
    '{1'b1, OFS_COMMAND, 32'h03, 32'h0}, '{1'b1, OFS_DATA1, 32'h0002, 32'h0},
    '{1'b1, OFS_COMMAND, 32'h06, 32'h0}, '{1'b0, OFS_DATA1, 32'h0, 32'h0006},
    '{1'b1, OFS_DATA1, 32'h0001, 32'h0}, '{1'b1, OFS_DATA2, 32'h000a, 32'h0},
    '{1'b1, OFS_DATA3, 32'h0003, 32'h0}, '{1'b1, OFS_COMMAND, 32'h05, 32'h0},
    '{1'b0, OFS_DATA2, 32'h0, 32'h0015}, '{1'b0, OFS_DATA3, 32'h0, 32'h0003},
    '{1'b0, OFS_STATUS, 32'h0, 32'h912f}
  };

  hscp_config_port hscp_config_port_inst (
    .SYS_CLK_IN(sys_clk), .RESET_IN(reset), .AVS_ADDRESS_IN(address), .AVS_READ_IN(read),
    .AVS_WRITE_IN(write), .AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(byte_en),
    .AVS_READDATA_OUT(readdata), .AVS_WAITREQUEST_OUT(waitreq), .AUX_INPUT_LINES_IN(aux_in),
    .DETECTOR_INPUTS_IN(det_in), .AXIS_GP_INPUT_IN(gp_in), .AXIS_ALT_FUNC_IN(alt_in),
    .AUX_OUTPUT_LINES_OUT(aux_out), .AXIS_GP_OUTPUT_OUT(gp_out), .SYNC_START_OUT(sync_out)
  );

  // ==========================================================================
  // clock, sync pulse monitor, watchdog
  always #4 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    if (sync_out !== 4'h0) begin
      sync_cnt++;
      sync_val = sync_out;
    end
  end

  initial begin
    repeat (5000) @(posedge sys_clk);
    miscompares++;
    final_report();
  end

  // ==========================================================================
  // tasks
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one bus cycle: hold the request until waitrequest is seen low
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    int n;
    @(posedge sys_clk);
    address <= a;
    write <= w;
    read <= !w;
    wdata <= d;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (waitreq !== 1'b0 && n < 20);
    if (n >= 20) chk("waitrequest", 32'h0, 32'h1);
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask

  task automatic final_report();
    if (miscompares == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    foreach (rows[i]) begin
      bus(rows[i].wr, rows[i].addr, rows[i].data, q);
      if (!rows[i].wr) chk($sformatf("row %0d", i), rows[i].exp, q);
    end
    @(posedge sys_clk);
    chk("gp_out", 32'he, {28'h0, gp_out});
    bus(1'b1, OFS_COMMAND, 32'h04, q);
    repeat (4) @(posedge sys_clk);
    chk("sync count", 32'h1, sync_cnt);
    chk("sync axes", 32'h6, {28'h0, sync_val});
    // input change shows only after the synchroniser
    aux_in <= 4'h6;
    bus(1'b0, OFS_STATUS, 32'h0, q);
    chk("status early", 32'h912f, q);
    repeat (6) @(posedge sys_clk);
    bus(1'b0, OFS_STATUS, 32'h0, q);
    chk("status late", 32'h972f, q);
    // reset in mid-run clears every setting
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk("reset outs", 32'h1000, {19'h0, waitreq, aux_out, gp_out, sync_out});
    reset <= 1'b0;
    bus(1'b0, OFS_STATUS, 32'h0, q);
    chk("status reset", 32'h0, q);
    bus(1'b0, OFS_DATA1, 32'h0, q);
    chk("data1 reset", 32'h0, q);
    // pulse outputs: timed by pause release, by an assigned input and by a detector edge
    bus(1'b1, OFS_DATA1, 32'h0006, q);
    bus(1'b1, OFS_COMMAND, {24'h0, CMD_SYNC_SETUP}, q);
    bus(1'b1, OFS_DATA1, 32'h0001, q);
    bus(1'b1, OFS_COMMAND, {24'h0, CMD_IN_SETUP}, q);
    bus(1'b1, OFS_DATA1, 32'h000e, q);
    bus(1'b1, OFS_DATA2, 32'h0002, q);
    bus(1'b1, OFS_COMMAND, {24'h0, CMD_OUT_SETUP}, q);
    bus(1'b1, OFS_COMMAND, {24'h0, CMD_PAUSE_RELEASE}, q);
    repeat (2) @(posedge sys_clk);
    chk("pulse start", 32'h1, {28'h0, aux_out});
    repeat (TICK_CYCLES - 1) @(posedge sys_clk);
    chk("pulse held", 32'h1, {28'h0, aux_out});
    repeat (TICK_CYCLES + 5) @(posedge sys_clk);
    chk("pulse ended", 32'h0, {28'h0, aux_out});
    chk("sync pause", 32'h2, sync_cnt);
    aux_in <= 4'h7;
    det_in <= 2'h1;
    repeat (8) @(posedge sys_clk);
    chk("pin pulses", 32'h3, {28'h0, aux_out});
    chk("sync pin", 32'h3, sync_cnt);
    chk("sync pin axes", 32'h6, {28'h0, sync_val});
    final_report();
  end
endmodule // test_hscp_config_port
